//--- hdl/brf_core.sv
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module brf_core #(
    parameter int SLOW_DIV = brf_pkg::SLOW_OSC_DIV
) (
    input  wire logic                CORE_CLK,
    input  wire logic                RESETN,
    input  wire logic [7:0]          REG_ADDR,
    input  wire logic [7:0]          REG_WDATA,
    input  wire logic                REG_WR,
    input  wire logic                REG_RD,
    output logic      [7:0]          REG_RDATA,
    input  wire logic                TIMED_UNLOCK,
    input  wire logic [7:0]          CONFIG_BYTE_TWO,
    input  wire logic                BOD_BELOW,
    input  wire logic                SW_RESET_EVT,
    input  wire logic                PIN_RESET_EVT,
    input  wire logic                PC_OVER_FLASH,
    input  wire logic                DEBUG_MODE,
    input  wire logic                DEBUG_ENABLE_SETTING,
    output logic                     BOD_ENABLE,
    output brf_pkg::brf_level_e      BOD_LEVEL_SEL,
    output logic                     RESET_REQ,
    output logic                     BOD_INT_REQ,
    output logic                     IRQ
);
    import brf_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    logic             load_pend_ff;
    logic             bod_en_ff;
    brf_level_e       bod_lvl_ff;
    logic             bod_rsten_ff;
    logic             bod_evt_ff;
    logic             bod_rflag_ff;
    logic             bod_state_ff;
    logic             sw_flag_ff;
    logic             pinrf_ff;
    logic             hf_flag_ff;
    logic             ie_global_ff;
    logic             ie_bod_ff;
    logic [EVT_W-1:0] evt_status_ff;
    logic [EVT_W-1:0] evt_mask_ff;
    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] evt_clr;
    logic             prev_below_ff;
    logic             live_prev_ff;
    logic             reset_req_ff;
    logic             bod_int_ff;
    logic             irq_ff;
    logic [7:0]       rdata_ff;
    logic [7:0]       nxt_rdata;
    logic             bod_valid;
    logic             cmp_live;
    logic             bod_event;
    logic             bod_drop;
    logic             bod_rst;
    logic             hf_suppress;
    logic             hf_rst;
    logic             reload;
    logic             wr_aux;
    logic             wr_ctrl;
    logic             wr_ie;
    logic             wr_evt;
    logic             wr_mask;

    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
        addr_hit = (addr == target);
    endfunction

    // ************************************************************
    // Detector blanking
    // ************************************************************
    brf_blank #(
        .DIV   (SLOW_DIV),
        .TICKS (BOD_BLANK_TICKS)
    ) u_blank (
        .clk   (CORE_CLK),
        .rst_n (RESETN),
        .en    (bod_en_ff),
        .valid (bod_valid)
    );

    // ************************************************************
    // Reset sources
    // ************************************************************
    assign reload      = load_pend_ff | SW_RESET_EVT | PIN_RESET_EVT | reset_req_ff;
    assign cmp_live    = bod_en_ff & bod_valid;
    assign bod_event   = cmp_live & live_prev_ff & (BOD_BELOW ^ prev_below_ff);
    assign bod_drop    = bod_event & BOD_BELOW;
    assign bod_rst     = bod_drop & bod_rsten_ff;
    assign hf_suppress = DEBUG_MODE & ~DEBUG_ENABLE_SETTING;
    assign hf_rst      = PC_OVER_FLASH & ~hf_suppress;

    // ************************************************************
    // Write decode
    // ************************************************************
    assign wr_aux  = REG_WR & addr_hit(REG_ADDR, ADDR_AUX_FLAGS);
    assign wr_ctrl = REG_WR & addr_hit(REG_ADDR, ADDR_BOD_CTRL) & TIMED_UNLOCK;
    assign wr_ie   = REG_WR & addr_hit(REG_ADDR, ADDR_IRQ_ENABLE);
    assign wr_evt  = REG_WR & addr_hit(REG_ADDR, ADDR_EVT_STATUS);
    assign wr_mask = REG_WR & addr_hit(REG_ADDR, ADDR_EVT_MASK);

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            load_pend_ff <= RST_LOAD_PND;
        end else begin
            load_pend_ff <= 1'b0;
        end
    end

    // ************************************************************
    // Comparator tracking
    // ************************************************************
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            prev_below_ff <= 1'b0;
            live_prev_ff  <= 1'b0;
            bod_state_ff  <= 1'b0;
        end else begin
            prev_below_ff <= BOD_BELOW;
            live_prev_ff  <= cmp_live;
            bod_state_ff  <= cmp_live & BOD_BELOW;
        end
    end

    // ************************************************************
    // Brown-out control fields
    // ************************************************************
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            bod_en_ff    <= RST_FLAG;
            bod_lvl_ff   <= BRF_LVL_4V4;
            bod_rsten_ff <= RST_FLAG;
        end else if (reload) begin
            bod_en_ff    <= CONFIG_BYTE_TWO[CFG_EN_BIT];
            bod_lvl_ff   <= brf_level_e'(CONFIG_BYTE_TWO[CFG_LVL_LSB +: 2]);
            bod_rsten_ff <= CONFIG_BYTE_TWO[CFG_RSTEN_BIT];
        end else if (wr_ctrl) begin
            bod_en_ff    <= REG_WDATA[CTRL_EN_BIT];
            bod_lvl_ff   <= brf_level_e'(REG_WDATA[CTRL_LVL_LSB +: 2]);
            bod_rsten_ff <= REG_WDATA[CTRL_RSTEN_BIT];
        end
    end

    // ************************************************************
    // Brown-out flags
    // ************************************************************
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            bod_evt_ff <= RST_FLAG;
        end else if (reload) begin
            bod_evt_ff <= CONFIG_BYTE_TWO[CFG_EN_BIT] & BOD_BELOW;
        end else if (bod_event) begin
            bod_evt_ff <= 1'b1;
        end else if (wr_ctrl) begin
            bod_evt_ff <= REG_WDATA[CTRL_EVT_BIT];
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            bod_rflag_ff <= RST_FLAG;
        end else if (bod_rst) begin
            bod_rflag_ff <= 1'b1;
        end else if (wr_ctrl) begin
            bod_rflag_ff <= REG_WDATA[CTRL_RFLAG_BIT];
        end
    end

    // ************************************************************
    // Reset cause flags
    // ************************************************************
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            sw_flag_ff <= RST_FLAG;
            pinrf_ff   <= RST_FLAG;
            hf_flag_ff <= RST_FLAG;
        end else begin
            if (SW_RESET_EVT) begin
                sw_flag_ff <= 1'b1;
            end else if (wr_aux) begin
                sw_flag_ff <= REG_WDATA[AUX_SW_BIT];
            end
            if (PIN_RESET_EVT) begin
                pinrf_ff <= 1'b1;
            end else if (wr_aux) begin
                pinrf_ff <= REG_WDATA[AUX_PIN_BIT];
            end
            if (PC_OVER_FLASH) begin
                hf_flag_ff <= 1'b1;
            end else if (wr_aux) begin
                hf_flag_ff <= REG_WDATA[AUX_HF_BIT];
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            reset_req_ff <= 1'b0;
        end else begin
            reset_req_ff <= bod_rst | hf_rst;
        end
    end

    // ************************************************************
    // Interrupt enables and request
    // ************************************************************
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            ie_global_ff <= RST_FLAG;
            ie_bod_ff    <= RST_FLAG;
        end else if (wr_ie) begin
            ie_global_ff <= REG_WDATA[IE_GLOBAL_BIT];
            ie_bod_ff    <= REG_WDATA[IE_BOD_BIT];
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            bod_int_ff <= 1'b0;
        end else begin
            bod_int_ff <= bod_evt_ff & ie_bod_ff & ie_global_ff;
        end
    end

    // ************************************************************
    // Event status and mask
    // ************************************************************
    always_comb begin
        evt_set                = RST_EVT;
        evt_set[EVT_BOD_BIT]   = bod_event;
        evt_set[EVT_BODRST_BIT] = bod_rst;
        evt_set[EVT_HF_BIT]    = PC_OVER_FLASH;
        evt_set[EVT_PIN_BIT]   = PIN_RESET_EVT;
        evt_set[EVT_SW_BIT]    = SW_RESET_EVT;
        evt_clr                = wr_evt ? REG_WDATA[EVT_W-1:0] : RST_EVT;
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            evt_status_ff <= RST_EVT;
            evt_mask_ff   <= RST_EVT;
            irq_ff        <= 1'b0;
        end else begin
            evt_status_ff <= (evt_status_ff & ~evt_clr) | evt_set;
            if (wr_mask) begin
                evt_mask_ff <= REG_WDATA[EVT_W-1:0];
            end
            irq_ff <= |(evt_status_ff & evt_mask_ff);
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    always_comb begin
        nxt_rdata = 8'h00;
        if (REG_RD) begin
            if (addr_hit(REG_ADDR, ADDR_AUX_FLAGS)) begin
                nxt_rdata[AUX_SW_BIT]  = sw_flag_ff;
                nxt_rdata[AUX_PIN_BIT] = pinrf_ff;
                nxt_rdata[AUX_HF_BIT]  = hf_flag_ff;
            end else if (addr_hit(REG_ADDR, ADDR_BOD_CTRL)) begin
                nxt_rdata[CTRL_EN_BIT]            = bod_en_ff;
                nxt_rdata[CTRL_LVL_LSB +: 2]      = bod_lvl_ff;
                nxt_rdata[CTRL_EVT_BIT]           = bod_evt_ff;
                nxt_rdata[CTRL_RSTEN_BIT]         = bod_rsten_ff;
                nxt_rdata[CTRL_RFLAG_BIT]         = bod_rflag_ff;
                nxt_rdata[CTRL_STATE_BIT]         = bod_state_ff;
            end else if (addr_hit(REG_ADDR, ADDR_IRQ_ENABLE)) begin
                nxt_rdata[IE_GLOBAL_BIT] = ie_global_ff;
                nxt_rdata[IE_BOD_BIT]    = ie_bod_ff;
            end else if (addr_hit(REG_ADDR, ADDR_EVT_STATUS)) begin
                nxt_rdata[EVT_W-1:0] = evt_status_ff;
            end else if (addr_hit(REG_ADDR, ADDR_EVT_MASK)) begin
                nxt_rdata[EVT_W-1:0] = evt_mask_ff;
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign REG_RDATA     = rdata_ff;
    assign BOD_ENABLE    = bod_en_ff;
    assign BOD_LEVEL_SEL = bod_lvl_ff;
    assign RESET_REQ     = reset_req_ff;
    assign BOD_INT_REQ   = bod_int_ff;
    assign IRQ           = irq_ff;

    // ************************************************************
    // Checks
    // ************************************************************
    AST_SW_FLAG: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        SW_RESET_EVT |=> sw_flag_ff)
        else $error("software reset flag not set");

    AST_PIN_FLAG: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        PIN_RESET_EVT |=> pinrf_ff)
        else $error("pin reset flag not set");

    AST_HF_RESET: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        (PC_OVER_FLASH && !hf_suppress) |=> (RESET_REQ && hf_flag_ff))
        else $error("hard fault did not reset");

    AST_HF_DEBUG: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        (PC_OVER_FLASH && hf_suppress && !bod_rst) |=> (!RESET_REQ && hf_flag_ff))
        else $error("hard fault reset not suppressed in debug");

    AST_STATE_OFF: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        !bod_en_ff |=> !bod_state_ff)
        else $error("status high with detector off");

    AST_EVT_FLAG: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        (bod_event && !reload) |=> (bod_evt_ff && evt_status_ff[EVT_BOD_BIT]))
        else $error("crossing did not set event flag");

    AST_INT_REQ: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        BOD_INT_REQ == ($past(bod_evt_ff) && $past(ie_bod_ff) && $past(ie_global_ff)))
        else $error("brown-out request mismatch");

    AST_BOD_RESET: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        bod_drop |=> (RESET_REQ == $past(bod_rsten_ff) || $past(hf_rst)))
        else $error("brown-out reset does not follow enable");

    AST_RST_FLAG: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        bod_rst |=> (bod_rflag_ff && reload))
        else $error("brown-out reset flag or reload missing");

    AST_RELOAD: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        reload |=> (bod_en_ff == $past(CONFIG_BYTE_TWO[CFG_EN_BIT])
                    && bod_rsten_ff == $past(CONFIG_BYTE_TWO[CFG_RSTEN_BIT])))
        else $error("fields not reloaded from config byte");

    AST_UNLOCK_GATE: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        (REG_WR && addr_hit(REG_ADDR, ADDR_BOD_CTRL) && !TIMED_UNLOCK && !reload)
        |=> ($stable(bod_en_ff) && $stable(bod_rsten_ff) && $stable(bod_lvl_ff)))
        else $error("locked control register changed");

    AST_KEEP_FLAG: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        (sw_flag_ff && !wr_aux) |=> sw_flag_ff)
        else $error("software reset flag lost");

endmodule
`default_nettype wire

//--- shared/brf_pkg.sv
`default_nettype none
package brf_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] ADDR_AUX_FLAGS  = 8'hA2;
    localparam logic [7:0] ADDR_BOD_CTRL   = 8'hA3;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hA8;
    localparam logic [7:0] ADDR_EVT_STATUS = 8'hF0;
    localparam logic [7:0] ADDR_EVT_MASK   = 8'hF1;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int AUX_SW_BIT     = 7;
    localparam int AUX_PIN_BIT    = 6;
    localparam int AUX_HF_BIT     = 5;
    localparam int CTRL_EN_BIT    = 7;
    localparam int CTRL_LVL_LSB   = 4;
    localparam int CTRL_EVT_BIT   = 3;
    localparam int CTRL_RSTEN_BIT = 2;
    localparam int CTRL_RFLAG_BIT = 1;
    localparam int CTRL_STATE_BIT = 0;
    localparam int CFG_EN_BIT     = 7;
    localparam int CFG_LVL_LSB    = 4;
    localparam int CFG_RSTEN_BIT  = 2;
    localparam int IE_GLOBAL_BIT  = 7;
    localparam int IE_BOD_BIT     = 5;
    localparam int EVT_BOD_BIT    = 0;
    localparam int EVT_BODRST_BIT = 1;
    localparam int EVT_HF_BIT     = 2;
    localparam int EVT_PIN_BIT    = 3;
    localparam int EVT_SW_BIT     = 4;
    localparam int EVT_W          = 5;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic             RST_FLAG     = 1'b0;
    localparam logic             RST_LOAD_PND = 1'b1;
    localparam logic [EVT_W-1:0] RST_EVT      = 5'h00;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CORE_CLK_HZ     = 10000000;
    localparam int SLOW_OSC_HZ     = 10000;
    localparam int SLOW_OSC_DIV    = CORE_CLK_HZ / SLOW_OSC_HZ;
    localparam int BOD_BLANK_TICKS = 3;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        BRF_LVL_4V4 = 2'b00,
        BRF_LVL_3V7 = 2'b01,
        BRF_LVL_2V7 = 2'b10,
        BRF_LVL_2V2 = 2'b11
    } brf_level_e;

    typedef enum logic [1:0] {
        BRF_BLK_OFF  = 2'b00,
        BRF_BLK_WAIT = 2'b01,
        BRF_BLK_ON   = 2'b11
    } brf_blank_e;

endpackage
`default_nettype wire

//--- hdl/brf_blank.sv
`timescale 1ns/1ps
`default_nettype none
module brf_blank #(
    parameter int DIV   = brf_pkg::SLOW_OSC_DIV,
    parameter int TICKS = brf_pkg::BOD_BLANK_TICKS
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic en,
    output logic      valid
);
    import brf_pkg::*;

    brf_blank_e  state_ff;
    logic [15:0] div_cnt_ff;
    logic [15:0] nxt_div_cnt;
    logic [2:0]  tick_cnt_ff;
    logic        tick;

    // ************************************************************
    // Slow oscillator tick
    // ************************************************************
    always_comb begin
        nxt_div_cnt = div_cnt_ff;
        tick        = 1'b0;
        if (!en) begin
            nxt_div_cnt = 16'h0000;
        end else if (div_cnt_ff == 16'(DIV - 1)) begin
            nxt_div_cnt = 16'h0000;
            tick        = 1'b1;
        end else begin
            nxt_div_cnt = div_cnt_ff + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_ff <= 16'h0000;
        end else begin
            div_cnt_ff <= nxt_div_cnt;
        end
    end

    // ************************************************************
    // Blanking state
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff    <= BRF_BLK_OFF;
            tick_cnt_ff <= 3'h0;
        end else if (!en) begin
            state_ff    <= BRF_BLK_OFF;
            tick_cnt_ff <= 3'h0;
        end else begin
            unique case (state_ff)
                BRF_BLK_OFF: begin
                    state_ff    <= BRF_BLK_WAIT;
                    tick_cnt_ff <= 3'h0;
                end
                BRF_BLK_WAIT: begin
                    if (tick) begin
                        tick_cnt_ff <= tick_cnt_ff + 3'h1;
                        if (tick_cnt_ff == 3'(TICKS - 1)) begin
                            state_ff <= BRF_BLK_ON;
                        end
                    end
                end
                BRF_BLK_ON: begin
                    state_ff <= BRF_BLK_ON;
                end
                default: begin
                    state_ff <= BRF_BLK_OFF;
                end
            endcase
        end
    end

    assign valid = (state_ff == BRF_BLK_ON);

    AST_BLANK_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(en) |=> !valid [*2])
        else $error("detector valid too soon after enable");

    AST_BLANK_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        !en |=> !valid)
        else $error("detector valid while disabled");

endmodule
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import brf_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic       clk, rstn, wr, rd_s, unlock, below, dbg, dbg_en;
    logic [7:0] addr, wdata, rdata, cfg;
    logic [2:0] ev;
    logic       bod_en, reset_req, bod_int, irq;
    brf_level_e lvl;
    int         err_total, n_checks;
    int         rst_cnt = 0;

    brf_core #(.SLOW_DIV(4)) u_dut (
        .CORE_CLK(clk), .RESETN(rstn), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd_s), .REG_RDATA(rdata), .TIMED_UNLOCK(unlock),
        .CONFIG_BYTE_TWO(cfg), .BOD_BELOW(below), .SW_RESET_EVT(ev[0]),
        .PIN_RESET_EVT(ev[1]), .PC_OVER_FLASH(ev[2]), .DEBUG_MODE(dbg),
        .DEBUG_ENABLE_SETTING(dbg_en), .BOD_ENABLE(bod_en), .BOD_LEVEL_SEL(lvl),
        .RESET_REQ(reset_req), .BOD_INT_REQ(bod_int), .IRQ(irq));

    // ****************************************
    // Clock, watchdog, reset request count
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        give_verdict();
    end
    always @(posedge clk) begin
        if (reset_req === 1'b1) rst_cnt <= rst_cnt + 1;
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(negedge clk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk);
        rd_s <= 1'b1; addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        @(negedge clk);
        chk("rdata", rdata & m, e);
    endtask
    task automatic pulse(input logic [2:0] k);
        @(posedge clk);
        ev <= k;
        @(posedge clk);
        ev <= 3'h0;
        idle(3);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rstn = 1'b0; wr = 1'b0; rd_s = 1'b0; unlock = 1'b0; below = 1'b0;
        dbg = 1'b0; dbg_en = 1'b0; addr = 8'h00; wdata = 8'h00;
        cfg = 8'hA4; ev = 3'h0; err_total = 0; n_checks = 0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        idle(2);
        rdc(8'hA3, 8'hFF, 8'hA4);
        rdc(8'hA2, 8'hE0, 8'h00);
        rdc(8'h55, 8'hFF, 8'h00);
        chk("level", {6'h00, lvl}, 8'h02);
        idle(30);
        wrr(8'hF1, 8'h1F);
        wrr(8'hA8, 8'hA0);
        @(posedge clk);
        below <= 1'b1;
        idle(4);
        chk("rst_cnt", rst_cnt[7:0], 8'h01);
        rdc(8'hA3, 8'h0A, 8'h0A);
        rdc(8'hF0, 8'hFF, 8'h03);
        chk("irq", {7'h00, irq}, 8'h01);
        chk("bod_int", {7'h00, bod_int}, 8'h01);
        wrr(8'hA8, 8'h80);
        idle(2);
        chk("bod_int", {7'h00, bod_int}, 8'h00);
        wrr(8'hF0, 8'h03);
        idle(2);
        chk("irq", {7'h00, irq}, 8'h00);
        idle(30);
        wrr(8'hA3, 8'h00);
        rdc(8'hA3, 8'hFF, 8'hAF);
        @(posedge clk);
        unlock <= 1'b1;
        wrr(8'hA3, 8'hA4);
        rdc(8'hA3, 8'hFF, 8'hA5);
        for (int i = 0; i < 4; i++) begin
            wrr(8'hA3, {2'b00, i[1:0], 4'h0});
            chk("level", {6'h00, lvl}, {6'h00, i[1:0]});
        end
        chk("bod_en", {7'h00, bod_en}, 8'h00);
        rdc(8'hA3, 8'hFF, 8'h30);
        @(posedge clk);
        below <= 1'b0;
        idle(4);
        rdc(8'hF0, 8'hFF, 8'h00);
        wrr(8'hA3, 8'hA4);
        @(posedge clk);
        below <= 1'b1;
        idle(3);
        rdc(8'hF0, 8'hFF, 8'h00);
        chk("rst_cnt", rst_cnt[7:0], 8'h01);
        idle(30);
        @(posedge clk);
        below <= 1'b0;
        idle(4);
        rdc(8'hF0, 8'hFF, 8'h01);
        chk("rst_cnt", rst_cnt[7:0], 8'h01);
        wrr(8'hA3, 8'h04);
        pulse(3'h1);
        rdc(8'hA2, 8'hE0, 8'h80);
        chk("bod_en", {7'h00, bod_en}, 8'h01);
        chk("level", {6'h00, lvl}, 8'h02);
        pulse(3'h2);
        rdc(8'hA2, 8'hE0, 8'hC0);
        pulse(3'h4);
        chk("rst_cnt", rst_cnt[7:0], 8'h02);
        rdc(8'hA2, 8'hE0, 8'hE0);
        rdc(8'hF0, 8'hFF, 8'h1D);
        wrr(8'hA2, 8'h00);
        @(posedge clk);
        dbg <= 1'b1;
        pulse(3'h4);
        chk("rst_cnt", rst_cnt[7:0], 8'h02);
        rdc(8'hA2, 8'hE0, 8'h20);
        chk("irq", {7'h00, irq}, 8'h01);
        wrr(8'hA3, 8'h80);
        @(posedge clk);
        below <= 1'b1;
        idle(4);
        chk("rst_cnt", rst_cnt[7:0], 8'h02);
        rdc(8'hA3, 8'h0F, 8'h09);
        @(posedge clk);
        dbg_en <= 1'b1;
        pulse(3'h4);
        chk("rst_cnt", rst_cnt[7:0], 8'h03);
        give_verdict();
    end
endmodule
`default_nettype wire
